// ---- inc/dtg_pkg.sv ----
// Purpose: Shared constants and types of the dual DAC tone generator
// Assumes: 32-bit register port, byte offsets in 8-bit address
// Notes: Field positions for control, channel and status; reset values for control, tone, channel and direct
package dtg_pkg;
  // Widths
  localparam int DTG_CODE_W = 8;
  localparam int DTG_STEP_W = 16;
  localparam int DTG_NCH = 2;
  localparam int DTG_ADDR_W = 8;
  localparam int DTG_DATA_W = 32;
  localparam int DTG_LUT_W = 6;
  // Register offsets
  localparam logic [7:0] DTG_OFS_CTRL = 8'h00;
  localparam logic [7:0] DTG_OFS_TONE = 8'h04;
  localparam logic [7:0] DTG_OFS_CH0 = 8'h08;
  localparam logic [7:0] DTG_OFS_CH1 = 8'h0C;
  localparam logic [7:0] DTG_OFS_DIRECT = 8'h10;
  localparam logic [7:0] DTG_OFS_TRIG = 8'h14;
  localparam logic [7:0] DTG_OFS_STATUS = 8'h18;
  // Control register fields
  localparam int DTG_CTRL_PWR_LSB = 0;
  localparam int DTG_CTRL_FORCE_BIT = 2;
  localparam int DTG_CTRL_SIMUL_BIT = 3;
  localparam int DTG_CTRL_SRC_LSB = 4;
  localparam int DTG_CTRL_TRG_LSB = 8;
  // Channel configuration fields
  localparam int DTG_CFG_DC_LSB = 0;
  localparam int DTG_CFG_SCALE_LSB = 8;
  localparam int DTG_CFG_PHASE_LSB = 10;
  // Status fields
  localparam int DTG_STAT_ACC_LSB = 16;
  // Reset values
  localparam logic [31:0] DTG_CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] DTG_STEP_RST = 16'h0000;
  localparam logic [11:0] DTG_CFG_RST = 12'h000;
  localparam logic [15:0] DTG_DIRECT_RST = 16'h8080;
  // Code midpoint and limits
  localparam logic signed [9:0] DTG_MID = 10'sh080;
  localparam logic signed [9:0] DTG_MAX = 10'sh0FF;
  // Tone clock rate derived from the system clock
  localparam int DTG_SYS_HZ = 25_000_000;
  localparam int DTG_TONE_HZ = 8_000_000;
  localparam int DTG_RATE_GCD = 1_000_000;
  localparam int DTG_TICK_NUM = DTG_TONE_HZ / DTG_RATE_GCD;
  localparam int DTG_TICK_DEN = DTG_SYS_HZ / DTG_RATE_GCD;
  // Sources and triggers
  typedef enum logic [1:0] {
    DTG_SRC_TONE,
    DTG_SRC_DIRECT,
    DTG_SRC_DMA
  } dtg_src_type;
  typedef enum logic [1:0] {
    DTG_TRG_SW,
    DTG_TRG_SEQ,
    DTG_TRG_TICK
  } dtg_trg_type;
endpackage : dtg_pkg

// ---- core/dtg_cos_lut.sv ----
// Purpose: Cosine lookup over one full turn from a quarter table
// Assumes: Index is quadrant in the top two bits
// Notes: Output is signed, peak 127
`timescale 1ns/1ps
module dtg_cos_lut
  import dtg_pkg::*;
(
  // Phase in
  input wire logic [DTG_LUT_W-1:0] phaseIdx,
  // Sample out
  output logic signed [DTG_CODE_W-1:0] sample
);
  localparam logic [7:0] QTAB [16] = '{
    8'h7F, 8'h7E, 8'h7D, 8'h79, 8'h75, 8'h70, 8'h6A, 8'h62,
    8'h5A, 8'h51, 8'h47, 8'h3C, 8'h31, 8'h25, 8'h19, 8'h0C
  };
  logic [1:0] quad;
  logic [3:0] step;
  logic [7:0] mag;
  // Mirror odd quadrants, negate the middle two
  always_comb begin
    quad = phaseIdx[5:4];
    step = phaseIdx[3:0];
    if (quad[0]) begin
      mag = (step == 4'h0) ? 8'h00 : QTAB[4'(5'h10 - {1'b0, step})];
    end else begin
      mag = QTAB[step];
    end
    if (quad == 2'h1 || quad == 2'h2) begin
      sample = -$signed(mag);
    end else begin
      sample = $signed(mag);
    end
  end
endmodule : dtg_cos_lut

// ---- core/dtg_dac_front.sv ----
// Purpose: Two-channel DAC front end with tone, direct and DMA sources
// Assumes: All inputs synchronous to clk_sys; 25 MHz system clock
// Notes: Read data valid only in the cycle after the read strobe
`timescale 1ns/1ps
//
// Behaviour
// R01 - Two 8-bit channels, configured independently
// R02 - Channels convert alone or together
// R03 - Code from tone, direct register or DMA
// R04 - Power bit gates; software or sequencer updates
// R05 - Tone frequency is clock times step over 65536
// R06 - Tone generator yields cosine codes for either channel
// R07 - Scale divides tone by 1, 2, 4, 8
// R08 - DC offset added, sum saturates
// R09 - Phase shift of 0, 90, 180, 270 degrees
// R10 - DMA supplies one sample per update
// R11 - Force bit: audio clock and data drive DAC
// R12 - 16-bit accumulator adds step each tone tick
module dtg_dac_front
  import dtg_pkg::*;
#(
  parameter int CODE_W = DTG_CODE_W,
  parameter int STEP_W = DTG_STEP_W
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Register port
  input wire logic [DTG_ADDR_W-1:0] regAddr,
  input wire logic [DTG_DATA_W-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [DTG_DATA_W-1:0] regRdData,
  // Conversion sequencer
  input wire logic [DTG_NCH-1:0] seqUpdate,
  // Serial audio controller
  input wire logic audioClk,
  input wire logic [2*DTG_CODE_W-1:0] audioData,
  output logic dmaSampleTaken,
  // DAC side
  output logic [DTG_CODE_W-1:0] dacOutputCode0,
  output logic [DTG_CODE_W-1:0] dacOutputCode1,
  output logic [DTG_NCH-1:0] dacChannelPowerUp,
  output logic [DTG_NCH-1:0] dacUpdate
);
  generate
    if (CODE_W != DTG_CODE_W || STEP_W != DTG_STEP_W) begin : g_chk
      $error("dtg_dac_front: only 8-bit codes and 16-bit steps");
    end
  endgenerate

  // Control state
  logic dacDmaSourceSel;
  logic simulMode;
  logic [1:0] srcField [DTG_NCH];
  logic [1:0] trgField [DTG_NCH];
  logic [STEP_W-1:0] toneFreqStep;
  logic [CODE_W-1:0] toneDcOffset [DTG_NCH];
  logic [1:0] toneAmpScale [DTG_NCH];
  logic [1:0] tonePhaseSel [DTG_NCH];
  logic [CODE_W-1:0] dacDirectCodeReg [DTG_NCH];
  logic [DTG_NCH-1:0] swTrig;
  logic [CODE_W-1:0] codeReg [DTG_NCH];

  // Tone clock and generator
  logic [4:0] tickCnt;
  logic [5:0] next_tickSum;
  logic toneTick;
  logic [STEP_W-1:0] phaseAcc;

  // Audio edge and update events
  logic audioClkQ;
  logic audioEdge;
  logic [DTG_NCH-1:0] rawEvt;
  logic [DTG_NCH-1:0] upd;
  logic [DTG_NCH-1:0] takesDma;

  // Per-channel datapath
  logic signed [CODE_W-1:0] toneRaw [DTG_NCH];
  logic signed [CODE_W-1:0] toneScaled [DTG_NCH];
  logic signed [9:0] toneSum [DTG_NCH];
  logic [CODE_W-1:0] toneCode [DTG_NCH];
  logic [CODE_W-1:0] next_code [DTG_NCH];
  dtg_src_type effSrc [DTG_NCH];

  logic wrCtrl;
  logic wrTone;
  logic wrDirect;
  logic wrTrig;
  assign wrCtrl = regWrite && regAddr == DTG_OFS_CTRL;
  assign wrTone = regWrite && regAddr == DTG_OFS_TONE;
  assign wrDirect = regWrite && regAddr == DTG_OFS_DIRECT;
  assign wrTrig = regWrite && regAddr == DTG_OFS_TRIG;

  // Global control
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dacChannelPowerUp <= DTG_CTRL_RST[DTG_CTRL_PWR_LSB +: DTG_NCH];
      dacDmaSourceSel <= DTG_CTRL_RST[DTG_CTRL_FORCE_BIT];
      simulMode <= DTG_CTRL_RST[DTG_CTRL_SIMUL_BIT];
    end else if (wrCtrl) begin
      dacChannelPowerUp <= regWrData[DTG_CTRL_PWR_LSB +: DTG_NCH];
      dacDmaSourceSel <= regWrData[DTG_CTRL_FORCE_BIT];
      simulMode <= regWrData[DTG_CTRL_SIMUL_BIT];
    end
  end

  // Frequency step
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      toneFreqStep <= DTG_STEP_RST;
    end else if (wrTone) begin
      toneFreqStep <= regWrData[STEP_W-1:0];
    end
  end

  // Software conversion strobes
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      swTrig <= '0;
    end else begin
      swTrig <= wrTrig ? regWrData[DTG_NCH-1:0] : '0;
    end
  end

  // Tone tick at 8/25 of the system rate
  always_comb begin
    next_tickSum = {1'b0, tickCnt} + 6'(DTG_TICK_NUM);
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tickCnt <= '0;
      toneTick <= 1'b0;
    end else if (next_tickSum >= 6'(DTG_TICK_DEN)) begin
      tickCnt <= 5'(next_tickSum - 6'(DTG_TICK_DEN));
      toneTick <= 1'b1;
    end else begin
      tickCnt <= next_tickSum[4:0];
      toneTick <= 1'b0;
    end
  end

  // Phase accumulator wraps modulo 2^16
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      phaseAcc <= '0;
    end else if (toneTick) begin
      phaseAcc <= phaseAcc + toneFreqStep; // see R12, see R05
    end
  end

  // Audio clock rising edge
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      audioClkQ <= 1'b0;
    end else begin
      audioClkQ <= audioClk;
    end
  end
  assign audioEdge = audioClk && !audioClkQ;

  genvar ch;
  generate
    for (ch = 0; ch < DTG_NCH; ch++) begin : g_ch
      logic [1:0] quad;
      logic wrCfg;
      assign wrCfg = regWrite &&
        regAddr == DTG_OFS_CH0 + 8'(4 * ch);

      // Independent per-channel settings
      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          toneDcOffset[ch] <= DTG_CFG_RST[DTG_CFG_DC_LSB +: CODE_W];
          toneAmpScale[ch] <= DTG_CFG_RST[DTG_CFG_SCALE_LSB +: 2];
          tonePhaseSel[ch] <= DTG_CFG_RST[DTG_CFG_PHASE_LSB +: 2];
        end else if (wrCfg) begin // see R01
          toneDcOffset[ch] <= regWrData[DTG_CFG_DC_LSB +: CODE_W];
          toneAmpScale[ch] <= regWrData[DTG_CFG_SCALE_LSB +: 2];
          tonePhaseSel[ch] <= regWrData[DTG_CFG_PHASE_LSB +: 2];
        end
      end

      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          srcField[ch] <= DTG_CTRL_RST[DTG_CTRL_SRC_LSB + 2*ch +: 2];
          trgField[ch] <= DTG_CTRL_RST[DTG_CTRL_TRG_LSB + 2*ch +: 2];
        end else if (wrCtrl) begin // see R01
          srcField[ch] <= regWrData[DTG_CTRL_SRC_LSB + 2*ch +: 2];
          trgField[ch] <= regWrData[DTG_CTRL_TRG_LSB + 2*ch +: 2];
        end
      end

      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          dacDirectCodeReg[ch] <= DTG_DIRECT_RST[CODE_W*ch +: CODE_W];
        end else if (wrDirect) begin
          dacDirectCodeReg[ch] <= regWrData[CODE_W*ch +: CODE_W];
        end
      end

      // Quadrant shift before lookup
      assign quad = phaseAcc[STEP_W-1 -: 2] + tonePhaseSel[ch]; // see R09
      dtg_cos_lut u_lut (
        .phaseIdx({quad, phaseAcc[STEP_W-3 -: 4]}), // see R06
        .sample(toneRaw[ch])
      );

      // Scale, offset and clamp
      always_comb begin
        toneScaled[ch] = toneRaw[ch] >>> toneAmpScale[ch]; // see R07
        toneSum[ch] = DTG_MID + 10'(toneScaled[ch]) +
          10'($signed(toneDcOffset[ch]));
        if (toneSum[ch] < 10'sh000) begin // see R08
          toneCode[ch] = '0;
        end else if (toneSum[ch] > DTG_MAX) begin
          toneCode[ch] = '1;
        end else begin
          toneCode[ch] = toneSum[ch][CODE_W-1:0];
        end
      end

      // Source choice
      always_comb begin
        if (dacDmaSourceSel) begin
          effSrc[ch] = DTG_SRC_DMA; // see R11
        end else begin
          case (srcField[ch])
            DTG_SRC_TONE: effSrc[ch] = DTG_SRC_TONE;
            DTG_SRC_DMA: effSrc[ch] = DTG_SRC_DMA;
            default: effSrc[ch] = DTG_SRC_DIRECT;
          endcase
        end
        case (effSrc[ch])
          DTG_SRC_TONE: next_code[ch] = toneCode[ch]; // see R03
          DTG_SRC_DMA: next_code[ch] = audioData[CODE_W*ch +: CODE_W];
          default: next_code[ch] = dacDirectCodeReg[ch];
        endcase
      end

      // Trigger choice
      always_comb begin
        if (dacDmaSourceSel) begin
          rawEvt[ch] = audioEdge; // see R11
        end else begin
          case (trgField[ch])
            DTG_TRG_SW: rawEvt[ch] = swTrig[ch]; // see R04
            DTG_TRG_SEQ: rawEvt[ch] = seqUpdate[ch];
            DTG_TRG_TICK: rawEvt[ch] = toneTick;
            default: rawEvt[ch] = 1'b0;
          endcase
        end
      end

      // Powered channels only; together when linked
      assign upd[ch] = dacChannelPowerUp[ch] &&
        (simulMode ? |rawEvt : rawEvt[ch]); // see R02, see R04
      assign takesDma[ch] = upd[ch] && effSrc[ch] == DTG_SRC_DMA;

      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          codeReg[ch] <= DTG_DIRECT_RST[CODE_W*ch +: CODE_W];
        end else if (upd[ch]) begin
          codeReg[ch] <= next_code[ch];
        end
      end
    end
  endgenerate

  assign dacOutputCode0 = codeReg[0];
  assign dacOutputCode1 = codeReg[1];

  // Update and sample strobes
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dacUpdate <= '0;
      dmaSampleTaken <= 1'b0;
    end else begin
      dacUpdate <= upd;
      dmaSampleTaken <= |takesDma; // see R10
    end
  end

  // Read data, zero outside the answer cycle
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      regRdData <= '0;
    end else if (!regRead) begin
      regRdData <= '0;
    end else begin
      case (regAddr)
        DTG_OFS_CTRL: regRdData <= {20'h0,
          trgField[1], trgField[0], srcField[1], srcField[0],
          simulMode, dacDmaSourceSel, dacChannelPowerUp};
        DTG_OFS_TONE: regRdData <= {16'h0, toneFreqStep};
        DTG_OFS_CH0: regRdData <= {20'h0, tonePhaseSel[0],
          toneAmpScale[0], toneDcOffset[0]};
        DTG_OFS_CH1: regRdData <= {20'h0, tonePhaseSel[1],
          toneAmpScale[1], toneDcOffset[1]};
        DTG_OFS_DIRECT: regRdData <= {16'h0,
          dacDirectCodeReg[1], dacDirectCodeReg[0]};
        DTG_OFS_STATUS: regRdData <= {phaseAcc, codeReg[1], codeReg[0]};
        default: regRdData <= '0;
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  sequence forceEdgeSeq;
    dacDmaSourceSel && audioEdge && dacChannelPowerUp[0];
  endsequence
  sequence forceTakeSeq;
    dacUpdate[0] && dmaSampleTaken;
  endsequence

  chk_accum_step: assert property ( // see R12
    toneTick |=> phaseAcc == 16'($past(phaseAcc) + $past(toneFreqStep)))
    else $error("phase accumulator did not add the step");
  chk_accum_hold: assert property ( // see R05
    !toneTick && !$past(toneTick) |=> $stable(phaseAcc))
    else $error("phase accumulator moved without a tick");
  chk_tick_rate: assert property ( // see R05
    toneTick |=> !toneTick ##1 !toneTick ##[1:2] toneTick)
    else $error("tone tick spacing wrong");
  chk_power_gate: assert property ( // see R04
    !dacChannelPowerUp[0] |=> $stable(dacOutputCode0) && !dacUpdate[0])
    else $error("unpowered channel updated");
  chk_direct_path: assert property ( // see R03
    upd[1] && effSrc[1] == DTG_SRC_DIRECT
    |=> dacOutputCode1 == $past(dacDirectCodeReg[1]))
    else $error("direct code not taken");
  chk_force_data: assert property ( // see R11
    forceEdgeSeq |=> dacOutputCode0 == $past(audioData[7:0]) ##0
    forceTakeSeq)
    else $error("forced audio sample not taken");
  chk_simul_both: assert property ( // see R02
    simulMode && &dacChannelPowerUp && |rawEvt
    |=> dacUpdate == 2'h3)
    else $error("linked channels did not update together");
  chk_sat_high: assert property ( // see R08
    upd[0] && effSrc[0] == DTG_SRC_TONE && toneSum[0] > DTG_MAX
    |=> dacOutputCode0 == 8'hFF)
    else $error("tone sum did not saturate high");
  chk_scale_range: assert property ( // see R07
    toneAmpScale[0] == 2'h3 |-> toneScaled[0] >= -8'sd16 &&
    toneScaled[0] <= 8'sd15)
    else $error("eighth scale out of range");
  chk_phase_invert: assert property ( // see R09
    tonePhaseSel[1] == 2'(tonePhaseSel[0] + 2'h2)
    |-> toneRaw[1] == -toneRaw[0])
    else $error("half-turn shift is not an inversion");
  chk_dma_one: assert property ( // see R10
    takesDma[1] |=> dmaSampleTaken && dacUpdate[1])
    else $error("DMA update not acknowledged");
endmodule : dtg_dac_front

// ---- dv/dtg_far_model.sv ----
// Purpose: Far-side model of audio serializer and conversion sequencer
// Assumes: Drives only just after rising clk_sys edges
// Notes: Audio clock idles low; idle data is the inverted last sample
`timescale 1ns/1ps
module dtg_far_model
  import dtg_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Toward the front end
  output logic audioClk,
  output logic [2*DTG_CODE_W-1:0] audioData,
  output logic [DTG_NCH-1:0] seqUpdate
);
  initial begin
    audioClk = 1'b0;
    audioData = 16'h0000;
    seqUpdate = 2'h0;
  end
  // Sample held as a level for a strobed update
  task automatic holdSample(input logic [15:0] d);
    @(posedge clk_sys);
    audioData <= d;
  endtask : holdSample
  // One audio clock pulse per sample, hi cycles high
  task automatic sendSample(input logic [15:0] d, input int hi);
    @(posedge clk_sys);
    audioClk <= 1'b1;
    audioData <= d;
    repeat (hi) @(posedge clk_sys);
    audioClk <= 1'b0;
    audioData <= ~d;
  endtask : sendSample
  // One-cycle conversion request
  task automatic seqPulse(input int ch);
    @(posedge clk_sys);
    seqUpdate <= 2'(1 << ch);
    @(posedge clk_sys);
    seqUpdate <= 2'h0;
  endtask : seqPulse
endmodule : dtg_far_model

// ---- dv/tb_dual_dac_tone_generator.sv ----
// Purpose: Self-checking bench of the DAC front end
// Assumes: Far-side model drives audio and sequencer inputs
// Notes: Tone cases run with step zero so the phase stays at zero
`timescale 1ns/1ps
module tb_dual_dac_tone_generator
  import dtg_pkg::*;
;
  logic clk_sys, arst_n, regWrite, regRead, audioClk, dmaSampleTaken;
  logic [7:0] regAddr, dacOutputCode0, dacOutputCode1;
  logic [31:0] regWrData, regRdData, rd;
  logic [1:0] seqUpdate, dacChannelPowerUp, dacUpdate;
  logic [15:0] audioData, acc;
  int errTotal = 0, nTests = 0, upd0 = 0, upd1 = 0, dmaCnt = 0;
  int b0, b1, bd;
  dtg_dac_front u_dut (.clk_sys(clk_sys), .arst_n(arst_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRead(regRead), .regRdData(regRdData), .seqUpdate(seqUpdate),
    .audioClk(audioClk), .audioData(audioData),
    .dmaSampleTaken(dmaSampleTaken), .dacOutputCode0(dacOutputCode0),
    .dacOutputCode1(dacOutputCode1),
    .dacChannelPowerUp(dacChannelPowerUp), .dacUpdate(dacUpdate));
  dtg_far_model u_far (.clk_sys(clk_sys), .audioClk(audioClk),
    .audioData(audioData), .seqUpdate(seqUpdate));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // Pulse counters
  always @(posedge clk_sys) begin
    if (arst_n === 1'b1) begin
      upd0 <= upd0 + int'(dacUpdate[0] === 1'b1);
      upd1 <= upd1 + int'(dacUpdate[1] === 1'b1);
      dmaCnt <= dmaCnt + int'(dmaSampleTaken === 1'b1);
    end
  end
  task automatic complete_run;
    $display("Checks %0d, errors %0d", nTests, errTotal);
    if (errTotal == 0 && nTests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      errTotal++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic regWr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask : regWr
  task automatic regRd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1;
    d = regRdData;
  endtask : regRd
  task automatic rdCheck(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    regRd(a, v);
    check(v, exp);
  endtask : rdCheck
  task automatic settle;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : settle
  task automatic snap;
    b0 = upd0;
    b1 = upd1;
    bd = dmaCnt;
  endtask : snap
  function automatic logic [31:0] ctrlWord(input logic [1:0] pwr,
    input int frc, sim, input logic [1:0] s0, s1, t0, t1);
    return {20'h00000, t1, t0, s1, s0, 1'(sim), 1'(frc), pwr};
  endfunction : ctrlWord
  function automatic logic [31:0] toneExp(input int sc, ph,
    input logic [7:0] dc);
    int c;
    int v;
    c = (ph == 0) ? 127 : (ph == 2) ? -127 : 0;
    v = 128 + (c >>> sc) + int'($signed(dc));
    v = (v > 255) ? 255 : (v < 0) ? 0 : v;
    return 32'(v);
  endfunction : toneExp
  // Watchdog: whole sequence needs about 220 cycles
  initial begin
    #(40 * 20000);
    errTotal++;
    $display("Error at %0t: watchdog expired", $time);
    complete_run();
  end
  initial begin
    static logic [1:0] tSc [10] = '{0, 1, 2, 3, 0, 0, 0, 0, 3, 1};
    static logic [1:0] tPh [10] = '{0, 0, 0, 0, 1, 2, 3, 0, 2, 2};
    static logic [7:0] tDc [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h64, 8'h80, 8'h10};
    arst_n = 1'b0;
    regAddr = 8'h00;
    regWrData = 32'h0;
    regWrite = 1'b0;
    regRead = 1'b0;
    repeat (8) @(posedge clk_sys);
    arst_n <= 1'b1;
    #1;
    check(32'(dacOutputCode0), 32'h80);
    check(32'(dacOutputCode1), 32'h80);
    check(32'(dacChannelPowerUp), 32'h0);
    rdCheck(DTG_OFS_CTRL, 32'h0);
    rdCheck(DTG_OFS_TONE, 32'h0);
    rdCheck(DTG_OFS_DIRECT, 32'h8080);
    rdCheck(DTG_OFS_TRIG, 32'h0);
    rdCheck(8'h1C, 32'h0);
    // Direct source, software starts
    regWr(DTG_OFS_CTRL, ctrlWord(2'h3, 0, 0, 2'h1, 2'h3, 2'h0, 2'h0));
    regWr(DTG_OFS_DIRECT, 32'h5A3C);
    rdCheck(DTG_OFS_CTRL, 32'h00D3);
    settle();
    check(32'(dacChannelPowerUp), 32'h3);
    snap();
    regWr(DTG_OFS_TRIG, 32'h1);
    settle();
    check(32'(dacOutputCode0), 32'h3C);
    check(32'(dacOutputCode1), 32'h80);
    check(32'(upd0 - b0), 32'h1);
    check(32'(upd1 - b1), 32'h0);
    regWr(DTG_OFS_TRIG, 32'h2);
    settle();
    check(32'(dacOutputCode1), 32'h5A);
    rdCheck(DTG_OFS_STATUS, 32'h5A3C);
    // Simultaneous update from one start
    regWr(DTG_OFS_CTRL, ctrlWord(2'h3, 0, 1, 2'h1, 2'h1, 2'h0, 2'h0));
    regWr(DTG_OFS_DIRECT, 32'h1122);
    snap();
    regWr(DTG_OFS_TRIG, 32'h1);
    settle();
    check(32'(dacOutputCode0), 32'h22);
    check(32'(dacOutputCode1), 32'h11);
    check(32'(upd1 - b1), 32'h1);
    // Unpowered channel ignores starts
    regWr(DTG_OFS_CTRL, ctrlWord(2'h1, 0, 0, 2'h1, 2'h1, 2'h0, 2'h0));
    regWr(DTG_OFS_DIRECT, 32'h7766);
    snap();
    regWr(DTG_OFS_TRIG, 32'h3);
    settle();
    check(32'(dacOutputCode1), 32'h11);
    check(32'(upd1 - b1), 32'h0);
    check(32'(dacOutputCode0), 32'h66);
    // Sequencer start on channel 0
    regWr(DTG_OFS_CTRL, ctrlWord(2'h3, 0, 0, 2'h1, 2'h1, 2'h1, 2'h3));
    regWr(DTG_OFS_DIRECT, 32'h4433);
    u_far.seqPulse(0);
    settle();
    check(32'(dacOutputCode0), 32'h33);
    check(32'(dacOutputCode1), 32'h11);
    // Tone scale, offset and phase
    regWr(DTG_OFS_CTRL, ctrlWord(2'h3, 0, 0, 2'h0, 2'h0, 2'h0, 2'h0));
    regWr(DTG_OFS_CH1, 32'h0200);
    for (int i = 0; i < 10; i++) begin
      regWr(DTG_OFS_CH0, 32'({tPh[i], tSc[i], tDc[i]}));
      regWr(DTG_OFS_TRIG, 32'h3);
      settle();
      check(32'(dacOutputCode0),
        toneExp(tSc[i], tPh[i], tDc[i]));
      check(32'(dacOutputCode1), toneExp(2, 0, 8'h00));
    end
    // Tone tick rate as update source
    regWr(DTG_OFS_CTRL, ctrlWord(2'h1, 0, 0, 2'h0, 2'h0, 2'h2, 2'h3));
    settle();
    snap();
    repeat (25) @(posedge clk_sys);
    #1;
    check(32'(upd0 - b0), 32'h8);
    regWr(DTG_OFS_CTRL, ctrlWord(2'h3, 0, 0, 2'h0, 2'h0, 2'h3, 2'h3));
    // Phase advance over 25 cycles
    regWr(DTG_OFS_TONE, 32'h1234);
    regRd(DTG_OFS_STATUS, rd);
    acc = rd[31:16];
    repeat (23) @(posedge clk_sys);
    regRd(DTG_OFS_STATUS, rd);
    check(32'(16'(rd[31:16] - acc)), 32'h91A0);
    // Stream data on a software start
    regWr(DTG_OFS_CTRL, ctrlWord(2'h3, 0, 0, 2'h2, 2'h2, 2'h0, 2'h0));
    u_far.holdSample(16'hC3A5);
    snap();
    regWr(DTG_OFS_TRIG, 32'h3);
    settle();
    check(32'(dacOutputCode0), 32'hA5);
    check(32'(dacOutputCode1), 32'hC3);
    check(32'(dmaCnt - bd), 32'h1);
    // Audio clock drives updates
    regWr(DTG_OFS_CTRL, ctrlWord(2'h3, 1, 0, 2'h0, 2'h0, 2'h3, 2'h3));
    snap();
    u_far.sendSample(16'h1E2D, 1);
    u_far.sendSample(16'h0FF0, 5);
    settle();
    check(32'(dacOutputCode0), 32'hF0);
    check(32'(dacOutputCode1), 32'h0F);
    check(32'(upd0 - b0), 32'h2);
    check(32'(dmaCnt - bd), 32'h2);
    complete_run();
  end
endmodule : tb_dual_dac_tone_generator
